// *** hw/rus_pkg.sv ***
// Constants and types for the remote unit setup decode block.
// Assumes a 100 MHz system clock.
package rus_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYC       = TICK_US * CLK_MHZ;
  // Held-key wait in heartbeat ticks, far inside ten seconds
  localparam logic [7:0]  DISPLAY_TICKS  = 8'h01;
  localparam int unsigned INT_PULSE_CYC  = 4;
  localparam logic [2:0]  INT_PULSE_LAST = 3'(INT_PULSE_CYC - 1);
  localparam logic [2:0]  ZERO3          = 3'h0;
  localparam logic [2:0]  RATE_W8        = 3'h0;
  localparam logic [2:0]  RATE_W4        = 3'h3;
  localparam logic [2:0]  RATE_W2        = 3'h6;
  localparam logic [2:0]  RATE_W1        = 3'h2;
  // Edges the synchroniser needs before capture
  localparam logic [1:0]  SYNC_LAST      = 2'h2;
  localparam logic [11:0] MARK_ORIG_TX   = 12'h4F6;
  localparam logic [11:0] SPACE_ORIG_TX  = 12'h42E;
  localparam logic [11:0] MARK_ORIG_RX   = 12'h8B1;
  localparam logic [11:0] SPACE_ORIG_RX  = 12'h7E9;
  // Baud times ten, so 134.5 stays exact
  localparam logic [17:0] BAUD_X10 [16] = '{
    18'h001F4, 18'h002EE, 18'h0044C, 18'h00541, 18'h005DC, 18'h00BB8,
    18'h01770, 18'h02EE0, 18'h04650, 18'h04E20, 18'h05DC0, 18'h08CA0,
    18'h0BB80, 18'h11940, 18'h17700, 18'h2EE00};
  typedef struct packed {
    logic [7:0] id_s1;
    logic [7:0] id_s2;
    logic [7:0] rate_s1;
    logic [7:0] rate_s2;
  } rus_sync_t;
  typedef struct packed {
    logic       captured;
    logic [1:0] settle;
    logic [7:0] unit_id;
    logic [3:0] rate_idx;
    logic       bus_en_n;
    logic       rom_en_n;
    logic [16:0] tick_cnt;
    logic       heartbeat;
    logic [2:0] int_cnt;
    logic       int_out;
    logic [7:0] hold_ms;
    logic       show;
    logic [11:0] tx_hz;
    logic [11:0] rx_hz;
    logic [17:0] baud;
  } rus_state_t;
endpackage

// *** hw/rus_sync_if.sv ***
// Carries raw and synchronised switch banks between modules.
// Assumes one clock domain.
`timescale 1ns/1ns
`default_nettype none
interface rus_sync_if;
  logic [7:0] id_raw;
  logic [7:0] rate_raw;
  logic [7:0] id_sync;
  logic [7:0] rate_sync;
  modport src  (output id_raw, output rate_raw, input id_sync,
                input rate_sync);
  modport sync (input id_raw, input rate_raw, output id_sync,
                output rate_sync);
endinterface
`default_nettype wire

// *** hw/rus_switch_sync.sv ***
// Two-stage synchroniser for both switch banks.
// Assumes switches are asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module rus_switch_sync import rus_pkg::*; (
  input  wire logic  clk,
  input  wire logic  rst_n,
  rus_sync_if.sync   sw
);
  rus_sync_t s_reg;
  rus_sync_t s_next;
  always_comb begin
    s_next         = s_reg;
    s_next.id_s1   = sw.id_raw;
    s_next.id_s2   = s_reg.id_s1;
    s_next.rate_s1 = sw.rate_raw;
    s_next.rate_s2 = s_reg.rate_s1;
  end
  always_ff @(posedge clk or negedge rst_n) begin // [RL15]
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign sw.id_sync   = s_reg.id_s2;
  assign sw.rate_sync = s_reg.rate_s2;
endmodule
`default_nettype wire

// *** hw/rus_setup_decode.sv ***
// Setup decode, activity and modem frequency report for the remote unit.
// Assumes bus strobes are synchronous to clk; switches are not.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [RL1] Id from first bank, open is one
// [RL2] Each unit gets unique id 1..255
// [RL3] Rate index weights 8,4,2,1 on positions 1,4,7,3
// [RL4] Index selects one of sixteen baud rates
// [RL5] Switches sampled once after power-up
// [RL6] Buffer enable low during bus transfer
// [RL7] Program enable low only on rom fetch
// [RL8] Heartbeat pulse high once per millisecond
// [RL9] Interrupt pulses while controller communicates
// [RL10] Held enter shows id and rate within ten seconds; block shows only while remote_receive is also high
// [RL11] Originate transmit mark 1270, space 1070
// [RL12] Originate receive mark 2225, space 2025
// [RL13] Far controller uses answer frequency pair
// [RL14] Character completion raises serial interrupt
// [RL15] Switches synchronised before use
module rus_setup_decode import rus_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  id_switch_bank,
  input  wire logic [7:0]  rate_switch_bank,
  input  wire logic        xfer_active,
  input  wire logic        rom_fetch,
  input  wire logic        char_done,
  input  wire logic        enter_held,
  input  wire logic        remote_receive,
  input  wire logic        originate_mode,
  output logic [7:0]       unit_id,
  output logic [3:0]       rate_index,
  output logic [17:0]      baud_x10,
  output logic             bus_transfer_probe,
  output logic             program_fetch_probe,
  output logic             heartbeat_probe,
  output logic             interrupt_probe,
  output logic             show_setup,
  output logic [11:0]      tx_mark_hz,
  output logic [11:0]      rx_mark_hz
);
  rus_sync_if sw ();
  rus_state_t st_reg;
  rus_state_t st_next;
  logic        tick;

  function automatic logic [3:0] rate_of(input logic [7:0] b);
    rate_of = {b[RATE_W8], b[RATE_W4], b[RATE_W2], b[RATE_W1]}; // [RL3]
  endfunction

  assign sw.id_raw   = id_switch_bank;
  assign sw.rate_raw = rate_switch_bank;

  rus_switch_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .sw    (sw)
  );

  assign tick = (st_reg.tick_cnt == 17'(TICK_CYC - 1));

  always_comb begin
    st_next          = st_reg;
    st_next.bus_en_n = !xfer_active; // [RL6]
    st_next.rom_en_n = !(xfer_active && rom_fetch); // [RL7]
    st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + 17'h1;
    st_next.heartbeat = tick; // [RL8]
    if (!st_reg.captured) begin // [RL5]
      if (st_reg.settle != SYNC_LAST) begin
        st_next.settle = st_reg.settle + 2'h1;
      end else begin
        st_next.captured = 1'b1;
        st_next.unit_id  = sw.id_sync; // [RL1]
        st_next.rate_idx = rate_of(sw.rate_sync);
      end
    end
    if (char_done) begin // [RL14] [RL9]
      st_next.int_cnt = INT_PULSE_LAST;
      st_next.int_out = 1'b1;
    end else if (st_reg.int_cnt != ZERO3) begin
      st_next.int_cnt = st_reg.int_cnt - 3'h1;
    end else begin
      st_next.int_out = 1'b0;
    end
    if (!(remote_receive && enter_held)) begin
      st_next.hold_ms = '0;
      st_next.show    = 1'b0;
    end else if (st_reg.hold_ms != DISPLAY_TICKS && tick) begin
      st_next.hold_ms = st_reg.hold_ms + 8'h1;
    end else if (st_reg.hold_ms == DISPLAY_TICKS) begin
      st_next.show = 1'b1; // [RL10]
    end
    st_next.tx_hz = originate_mode ? MARK_ORIG_TX : SPACE_ORIG_TX;
    st_next.rx_hz = originate_mode ? MARK_ORIG_RX : SPACE_ORIG_RX;
    st_next.baud  = BAUD_X10[st_reg.rate_idx]; // [RL4]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg          <= '0;
      st_reg.bus_en_n <= 1'b1;
      st_reg.rom_en_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign unit_id             = st_reg.unit_id;
  assign rate_index          = st_reg.rate_idx;
  assign baud_x10            = st_reg.baud;
  assign bus_transfer_probe  = st_reg.bus_en_n;
  assign program_fetch_probe = st_reg.rom_en_n;
  assign heartbeat_probe     = st_reg.heartbeat;
  assign interrupt_probe     = st_reg.int_out;
  assign show_setup          = st_reg.show;
  assign tx_mark_hz          = st_reg.tx_hz; // [RL11]
  assign rx_mark_hz          = st_reg.rx_hz; // [RL12]

  property p_bus_en;
    @(posedge clk) disable iff (!rst_n)
      xfer_active |=> !bus_transfer_probe;
  endproperty
  a_bus_en: assert property (p_bus_en) else $error("buffer enable"); // [RL6]

  property p_bus_idle;
    @(posedge clk) disable iff (!rst_n)
      !xfer_active |=> bus_transfer_probe;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("bus idle"); // [RL6]

  property p_rom_en;
    @(posedge clk) disable iff (!rst_n)
      !program_fetch_probe |-> !bus_transfer_probe && $past(rom_fetch);
  endproperty
  a_rom_en: assert property (p_rom_en) else $error("rom enable"); // [RL7]

  property p_rom_go;
    @(posedge clk) disable iff (!rst_n)
      xfer_active && rom_fetch |=> !program_fetch_probe;
  endproperty
  a_rom_go: assert property (p_rom_go) else $error("rom fetch"); // [RL7]

  property p_hb;
    @(posedge clk) disable iff (!rst_n)
      heartbeat_probe |=> (!heartbeat_probe) [*8];
  endproperty
  a_hb: assert property (p_hb) else $error("heartbeat width"); // [RL8]

  property p_int;
    @(posedge clk) disable iff (!rst_n)
      char_done |=> interrupt_probe [*4];
  endproperty
  a_int: assert property (p_int) else $error("interrupt pulse"); // [RL14]

  property p_int_quiet;
    @(posedge clk) disable iff (!rst_n)
      !interrupt_probe && !char_done |=> !interrupt_probe;
  endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("quiet"); // [RL9]

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      st_reg.captured |=> $stable(unit_id) && $stable(rate_index);
  endproperty
  a_hold: assert property (p_hold) else $error("setup changed"); // [RL5]

  property p_id_src;
    @(posedge clk) disable iff (!rst_n)
      $rose(st_reg.captured) |-> unit_id == $past(id_switch_bank, 3);
  endproperty
  a_id_src: assert property (p_id_src) else $error("id"); // [RL1]

  property p_rate_src;
    @(posedge clk) disable iff (!rst_n)
      $rose(st_reg.captured) |->
        rate_index == {$past(rate_switch_bank[RATE_W8], 3),
                       $past(rate_switch_bank[RATE_W4], 3),
                       $past(rate_switch_bank[RATE_W2], 3),
                       $past(rate_switch_bank[RATE_W1], 3)};
  endproperty
  a_rate_src: assert property (p_rate_src) else $error("rate"); // [RL3]

  property p_tx;
    @(posedge clk) disable iff (!rst_n)
      originate_mode |=> tx_mark_hz == 12'h4F6;
  endproperty
  a_tx: assert property (p_tx) else $error("tx mark"); // [RL11]

  property p_tx_space;
    @(posedge clk) disable iff (!rst_n)
      !originate_mode |=> tx_mark_hz == 12'h42E;
  endproperty
  a_tx_space: assert property (p_tx_space) else $error("tx space"); // [RL11]

  property p_rx;
    @(posedge clk) disable iff (!rst_n)
      !originate_mode |=> rx_mark_hz == 12'h7E9;
  endproperty
  a_rx: assert property (p_rx) else $error("rx space"); // [RL12]

  property p_rx_mark;
    @(posedge clk) disable iff (!rst_n)
      originate_mode |=> rx_mark_hz == 12'h8B1;
  endproperty
  a_rx_mark: assert property (p_rx_mark) else $error("rx mark"); // [RL12]

  property p_show;
    @(posedge clk) disable iff (!rst_n)
      !enter_held |=> !show_setup;
  endproperty
  a_show: assert property (p_show) else $error("show"); // [RL10]

  property p_show_src;
    @(posedge clk) disable iff (!rst_n)
      show_setup |-> $past(remote_receive) && $past(enter_held);
  endproperty
  a_show_src: assert property (p_show_src) else $error("show src"); // [RL10]

  property p_show_hold;
    @(posedge clk) disable iff (!rst_n)
      show_setup && remote_receive && enter_held |=> show_setup;
  endproperty
  a_show_hold: assert property (p_show_hold) else $error("show hold"); // [RL10]

  property p_baud;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> baud_x10 == BAUD_X10[$past(rate_index)];
  endproperty
  a_baud: assert property (p_baud) else $error("baud"); // [RL4]
endmodule
`default_nettype wire

// *** verif/rus_cpu_model.sv ***
// Control processor model: bus transfers and character events.
// Assumes the block samples its inputs on the rising clk edge.
`timescale 1ns/1ns
`default_nettype none
module rus_cpu_model (
  input  wire logic clk,
  output logic      xfer_active,
  output logic      rom_fetch,
  output logic      char_done
);
  initial begin
    xfer_active = 1'b0;
    rom_fetch   = 1'b0;
    char_done   = 1'b0;
  end
  // One transfer held for n cycles
  task automatic xfer(input logic rom, input int n);
    xfer_active <= 1'b1;
    rom_fetch   <= rom;
    repeat (n) @(posedge clk);
    xfer_active <= 1'b0;
    rom_fetch   <= 1'b0;
  endtask
  // Serial character completed
  task automatic char_event();
    char_done <= 1'b1;
    @(posedge clk);
    char_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verif/remote_unit_setup_decode_tb_top.sv ***
// Bench for the setup decode block.
// Assumes a 100 MHz clock and the processor model beside it.
`timescale 1ns/1ns
`default_nettype none
module remote_unit_setup_decode_tb_top;
  import rus_pkg::*;
  localparam int BAUD [16] = '{500, 750, 1100, 1345, 1500, 3000, 6000,
    12000, 18000, 20000, 24000, 36000, 48000, 72000, 96000, 192000};
  // Far controller sends on the answer pair
  localparam int FAR_MARK  = 2225;
  localparam int FAR_SPACE = 2025;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  id_sw = 8'h00;
  logic [7:0]  rate_sw = 8'h00;
  logic        enter_held = 1'b0;
  logic        remote_rx = 1'b0;
  logic        orig = 1'b0;
  logic        xfer, rom, chr, bus_p, rom_p, hb_p, int_p, show;
  logic [7:0]  uid;
  logic [3:0]  ridx, ib;
  logic [17:0] baud;
  logic [11:0] tx_hz, rx_hz;
  logic [31:0] n;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #5 clk = ~clk;
  rus_cpu_model cpu (.clk(clk), .xfer_active(xfer), .rom_fetch(rom),
    .char_done(chr));
  rus_setup_decode dut (.clk(clk), .rst_n(rst_n), .id_switch_bank(id_sw),
    .rate_switch_bank(rate_sw), .xfer_active(xfer), .rom_fetch(rom),
    .char_done(chr), .enter_held(enter_held), .remote_receive(remote_rx),
    .originate_mode(orig), .unit_id(uid), .rate_index(ridx),
    .baud_x10(baud), .bus_transfer_probe(bus_p),
    .program_fetch_probe(rom_p), .heartbeat_probe(hb_p),
    .interrupt_probe(int_p), .show_setup(show), .tx_mark_hz(tx_hz),
    .rx_mark_hz(rx_hz));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 110000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    for (int i = 0; i < 16; i++) begin
      ib = 4'(i);
      id_sw <= 8'(i * 16 + 1);
      rate_sw <= {~ib[0], ib[1], ~ib[0], ~ib[0], ib[2], ib[0], ~ib[0], ib[3]};
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      #1 check(uid, 32'(i * 16 + 1));
      check(ridx, ib);
      check(baud, BAUD[i]);
      @(posedge clk);
    end
    @(posedge clk);
    id_sw <= ~id_sw;
    rate_sw <= ~rate_sw;
    repeat (5) @(posedge clk);
    #1 check(uid, 8'hF1);
    check(ridx, 4'hF);
    $display("Test setup done");
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      cpu.xfer(r[0], 3);
      #1 check(bus_p, 1'b0);
      check(rom_p, r[0] ? 1'b0 : 1'b1);
      @(posedge clk);
      #1 check({bus_p, rom_p}, 2'h3);
    end
    @(posedge clk);
    cpu.char_event();
    n = 0;
    repeat (8) begin
      #1 n = n + int_p;
      @(posedge clk);
    end
    check(n, 4);
    $display("Test bus done");
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      remote_rx <= 1'b1;
      orig <= m[0];
      repeat (2) @(posedge clk);
      #1 check(tx_hz, m ? 12'h4F6 : 12'h42E);
      check(rx_hz, m ? FAR_MARK : FAR_SPACE);
      check(show, 1'b0);
    end
    $display("Test modem done");
    @(posedge clk);
    enter_held <= 1'b1;
    n = 0;
    while (hb_p !== 1'b1 && n < 100005) begin
      @(posedge clk);
      #1 n++;
    end
    check(hb_p, 1'b1);
    check(show, 1'b0);
    @(posedge clk);
    #1 check(hb_p, 1'b0);
    check(show, 1'b1);
    @(posedge clk);
    enter_held <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(show, 1'b0);
    $display("Test heartbeat done");
    finish_test();
  end
endmodule
`default_nettype wire
